//--- cpar_cfg.svh
// constants for the core pointer and accumulator register block
// Functional notes
// - data pointer high byte is an 8-bit register at address 0x83, any page.
// - data pointer low byte at 0x82 pairs with high byte into 16-bit pointer.
// - stack top pointer is an 8-bit read/write register holding stack top.
// - a push increments the stack pointer first, then stores at new location.
// - stack top pointer resets to 0x07, not zero.
// - stack top pointer sits at address 0x81 on every page.
// - primary arithmetic register at 0xE0, any page, bit access, resets to zero.
// - primary register is the accumulator operand and result for arithmetic.
// - second operand register at 0xF0, any page, bit access, resets to zero.
// - second operand register holds second operand or second result byte.
`ifndef CPAR_CFG_SVH
`define CPAR_CFG_SVH
`define CPAR_ADDR_STACK 8'h81
`define CPAR_ADDR_PTR_LO 8'h82
`define CPAR_ADDR_PTR_HI 8'h83
`define CPAR_ADDR_ARITH 8'hE0
`define CPAR_ADDR_SECOND 8'hF0
`define CPAR_RST_STACK 8'h07
`define CPAR_RST_ZERO 8'h00
`define CPAR_BIT_SEL_MSB 7
`define CPAR_BIT_SEL_LSB 3
`define CPAR_BGRP_ARITH 5'h1C
`define CPAR_BGRP_SECOND 5'h1E
`endif

//--- cpar_pkg.sv
// types for the core pointer and accumulator register block
`default_nettype none
package cpar_pkg;
  typedef logic [7:0] cpar_byte_t;
endpackage : cpar_pkg
`default_nettype wire

//--- cpar_regs.sv
// core pointer, stack and accumulator special-function registers
`include "cpar_cfg.svh"
`default_nettype none

// one byte register with execution, byte and bit writes in falling priority
module cpar_arith_byte
  import cpar_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int IDX_W = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // execution unit write
  input wire logic exec_wr_i,
  input wire logic [WIDTH-1:0] exec_wdata_i,
  // byte write, already qualified by the address decode
  input wire logic byte_wr_i,
  input wire logic [WIDTH-1:0] byte_wdata_i,
  // bit write, already qualified by the address decode
  input wire logic bit_wr_i,
  input wire logic bit_wdata_i,
  input wire logic [IDX_W-1:0] bit_idx_i,
  // stored value
  output logic [WIDTH-1:0] value_o
);
  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  wire [WIDTH-1:0] bit_one = {{(WIDTH-1){1'b0}}, 1'b1};
  wire [WIDTH-1:0] bit_mask = bit_one << bit_idx_i;
  wire [WIDTH-1:0] bit_set = value_reg | bit_mask;
  wire [WIDTH-1:0] bit_clr = value_reg & ~bit_mask;
  wire [WIDTH-1:0] bit_result = bit_wdata_i ? bit_set : bit_clr;

  // execution result wins: an instruction must never lose its result to a store
  always_comb begin
    value_next = value_reg;
    if (exec_wr_i) begin
      value_next = exec_wdata_i;
    end else if (byte_wr_i) begin
      value_next = byte_wdata_i;
    end else if (bit_wr_i) begin
      value_next = bit_result;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      value_reg <= RST_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_o = value_reg;
endmodule : cpar_arith_byte

module cpar_regs
  import cpar_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // special-function byte port, page select ignored since all pages map here
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // bit access port: addr[7:3] picks the register, addr[2:0] the bit
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wr_i,
  input wire logic bit_wdata_i,
  output logic bit_rdata_o,
  output logic bit_hit_o,
  // execution unit
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic arith_wr_i,
  input wire logic [7:0] arith_wdata_i,
  input wire logic second_wr_i,
  input wire logic [7:0] second_wdata_i,
  input wire logic ptr_word_wr_i,
  input wire logic [15:0] ptr_word_wdata_i,
  output logic push_strobe_o,
  output logic [7:0] push_addr_o,
  output logic [15:0] data_pointer_word_o,
  output logic [7:0] primary_arith_o,
  output logic [7:0] second_operand_o,
  output logic [7:0] stack_top_pointer_o
);
  cpar_byte_t stack_top_pointer_reg;
  cpar_byte_t stack_top_pointer_next;
  cpar_byte_t data_pointer_low_byte;
  cpar_byte_t data_pointer_high_byte;
  cpar_byte_t primary_arith;
  cpar_byte_t second_operand;
  logic push_strobe_reg;
  cpar_byte_t push_addr_reg;
  cpar_byte_t push_addr_next;

  // byte address decode
  wire sel_stack = sfr_addr_i == `CPAR_ADDR_STACK;
  wire sel_ptr_lo = sfr_addr_i == `CPAR_ADDR_PTR_LO;
  wire sel_ptr_hi = sfr_addr_i == `CPAR_ADDR_PTR_HI;
  wire sel_arith = sfr_addr_i == `CPAR_ADDR_ARITH;
  wire sel_second = sfr_addr_i == `CPAR_ADDR_SECOND;
  wire wr_stack = sfr_wr_i & sel_stack;
  wire wr_ptr_lo = sfr_wr_i & sel_ptr_lo;
  wire wr_ptr_hi = sfr_wr_i & sel_ptr_hi;
  wire wr_arith = sfr_wr_i & sel_arith;
  wire wr_second = sfr_wr_i & sel_second;

  // bit address decode
  wire [4:0] bit_grp = bit_addr_i[`CPAR_BIT_SEL_MSB:`CPAR_BIT_SEL_LSB];
  wire [2:0] bit_idx = bit_addr_i[2:0];
  wire bsel_arith = bit_grp == `CPAR_BGRP_ARITH;
  wire bsel_second = bit_grp == `CPAR_BGRP_SECOND;
  wire bwr_arith = bit_wr_i & bsel_arith;
  wire bwr_second = bit_wr_i & bsel_second;

  // pointer word halves
  wire [7:0] ptr_word_lo = ptr_word_wdata_i[7:0];
  wire [7:0] ptr_word_hi = ptr_word_wdata_i[15:8];

  // stack arithmetic wraps at the byte boundary
  wire [7:0] stack_inc = stack_top_pointer_reg + 8'h01;
  wire [7:0] stack_dec = stack_top_pointer_reg - 8'h01;

  // hardware updates win over a software write in the same cycle
  always_comb begin
    stack_top_pointer_next = stack_top_pointer_reg;
    if (push_i) begin
      stack_top_pointer_next = stack_inc;
    end else if (pop_i) begin
      stack_top_pointer_next = stack_dec;
    end else if (wr_stack) begin
      stack_top_pointer_next = sfr_wdata_i;
    end
  end

  assign push_addr_next = push_i ? stack_inc : push_addr_reg;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      stack_top_pointer_reg <= `CPAR_RST_STACK;
      push_strobe_reg <= 1'b0;
      push_addr_reg <= `CPAR_RST_ZERO;
    end else begin
      stack_top_pointer_reg <= stack_top_pointer_next;
      push_strobe_reg <= push_i;
      push_addr_reg <= push_addr_next;
    end
  end

  // pointer low byte: no bit access, so its bit write is unused
  cpar_arith_byte #(
    .WIDTH(8),
    .IDX_W(3),
    .RST_VAL(`CPAR_RST_ZERO)
  ) u_ptr_lo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .exec_wr_i(ptr_word_wr_i),
    .exec_wdata_i(ptr_word_lo),
    .byte_wr_i(wr_ptr_lo),
    .byte_wdata_i(sfr_wdata_i),
    .bit_wr_i(1'b0),
    .bit_wdata_i(1'b0),
    .bit_idx_i(bit_idx),
    .value_o(data_pointer_low_byte)
  );

  // pointer high byte
  cpar_arith_byte #(
    .WIDTH(8),
    .IDX_W(3),
    .RST_VAL(`CPAR_RST_ZERO)
  ) u_ptr_hi (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .exec_wr_i(ptr_word_wr_i),
    .exec_wdata_i(ptr_word_hi),
    .byte_wr_i(wr_ptr_hi),
    .byte_wdata_i(sfr_wdata_i),
    .bit_wr_i(1'b0),
    .bit_wdata_i(1'b0),
    .bit_idx_i(bit_idx),
    .value_o(data_pointer_high_byte)
  );

  // primary arithmetic register, bit-addressable
  cpar_arith_byte #(
    .WIDTH(8),
    .IDX_W(3),
    .RST_VAL(`CPAR_RST_ZERO)
  ) u_arith (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .exec_wr_i(arith_wr_i),
    .exec_wdata_i(arith_wdata_i),
    .byte_wr_i(wr_arith),
    .byte_wdata_i(sfr_wdata_i),
    .bit_wr_i(bwr_arith),
    .bit_wdata_i(bit_wdata_i),
    .bit_idx_i(bit_idx),
    .value_o(primary_arith)
  );

  // second operand register, bit-addressable
  cpar_arith_byte #(
    .WIDTH(8),
    .IDX_W(3),
    .RST_VAL(`CPAR_RST_ZERO)
  ) u_second (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .exec_wr_i(second_wr_i),
    .exec_wdata_i(second_wdata_i),
    .byte_wr_i(wr_second),
    .byte_wdata_i(sfr_wdata_i),
    .bit_wr_i(bwr_second),
    .bit_wdata_i(bit_wdata_i),
    .bit_idx_i(bit_idx),
    .value_o(second_operand)
  );

  // reads are combinational so a write shows on the next cycle's read
  assign sfr_hit_o = sel_stack | sel_ptr_lo | sel_ptr_hi | sel_arith | sel_second;
  assign sfr_rdata_o = sel_stack ? stack_top_pointer_reg :
                       sel_ptr_lo ? data_pointer_low_byte :
                       sel_ptr_hi ? data_pointer_high_byte :
                       sel_arith ? primary_arith :
                       sel_second ? second_operand : 8'h00;
  assign bit_hit_o = bsel_arith | bsel_second;
  assign bit_rdata_o = bsel_arith ? primary_arith[bit_idx] :
                       bsel_second ? second_operand[bit_idx] : 1'b0;
  // store of the pushed byte is strobed in the same cycle that the incremented pointer shows
  assign push_strobe_o = push_strobe_reg;
  assign push_addr_o = push_addr_reg;
  assign data_pointer_word_o = {data_pointer_high_byte, data_pointer_low_byte};
  assign primary_arith_o = primary_arith;
  assign second_operand_o = second_operand;
  assign stack_top_pointer_o = stack_top_pointer_reg;
endmodule : cpar_regs
`default_nettype wire

//--- cpar_regs_checker.sv
// checker for the core pointer and accumulator registers
`default_nettype none
module cpar_regs_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic arith_wr_i,
  input wire logic [7:0] arith_wdata_i,
  input wire logic second_wr_i,
  input wire logic [7:0] second_wdata_i,
  input wire logic ptr_word_wr_i,
  input wire logic [15:0] ptr_word_wdata_i,
  input wire logic push_strobe_o,
  input wire logic [7:0] push_addr_o,
  input wire logic [15:0] data_pointer_word_o,
  input wire logic [7:0] primary_arith_o,
  input wire logic [7:0] second_operand_o,
  input wire logic [7:0] stack_top_pointer_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire sw_stack = sfr_wr_i && sfr_addr_i == 8'h81;
  a_stack_reset_val: assert property (disable iff (1'b0) !nrst_i |=> stack_top_pointer_o == 8'h07)
    else $error("stack reset");
  a_arith_reset_zero: assert property (disable iff (1'b0) !nrst_i |=>
    primary_arith_o == 8'h00 && second_operand_o == 8'h00) else $error("arith reset");
  a_push_pre_incr: assert property (push_i |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01)
    else $error("push inc");
  a_push_store_addr: assert property (push_i |=> push_strobe_o && push_addr_o == stack_top_pointer_o)
    else $error("push store");
  a_stack_holds_idle: assert property (!push_i && !pop_i && !sw_stack |=> $stable(stack_top_pointer_o))
    else $error("stack moved");
  a_stack_sfr_write: assert property (sw_stack && !push_i && !pop_i |=> stack_top_pointer_o == $past(sfr_wdata_i))
    else $error("stack write");
  a_arith_sfr_write: assert property (sfr_wr_i && sfr_addr_i == 8'hE0 && !arith_wr_i |=>
    primary_arith_o == $past(sfr_wdata_i)) else $error("arith write");
  a_second_sfr_write: assert property (sfr_wr_i && sfr_addr_i == 8'hF0 && !second_wr_i |=>
    second_operand_o == $past(sfr_wdata_i)) else $error("second write");
  a_ptr_hi_write: assert property (sfr_wr_i && sfr_addr_i == 8'h83 && !ptr_word_wr_i |=>
    data_pointer_word_o[15:8] == $past(sfr_wdata_i)) else $error("pointer high write");
  a_arith_exec_write: assert property (arith_wr_i |=> primary_arith_o == $past(arith_wdata_i))
    else $error("arith exec write");
  a_second_exec_write: assert property (second_wr_i |=> second_operand_o == $past(second_wdata_i))
    else $error("second exec write");
  a_ptr_word_write: assert property (ptr_word_wr_i |=> data_pointer_word_o == $past(ptr_word_wdata_i))
    else $error("pointer word write");
  c_push: cover property (push_i ##1 push_i);
  c_pop: cover property (pop_i);
  c_exec: cover property (ptr_word_wr_i && sfr_wr_i);
  c_hw_over_sw: cover property (push_i && sw_stack);
endmodule : cpar_regs_checker
bind cpar_regs cpar_regs_checker u_chk (.*);
`default_nettype wire

//--- cpar_regs_tb_top.sv
// self-checking bench for the core pointer and accumulator registers
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module cpar_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, nrst_i = 0, sw = 0, bw = 0, bd = 0, ps = 0, pp = 0, aw = 0, xw = 0, dw = 0;
  logic [7:0] sa = 0, sd = 0, ba = 0, ad = 0, xd = 0, rd, pa, arith, second, stk;
  logic [15:0] dd = 0, ptr;
  logic hit, bhit, brd, pstb;
  int miscompares = 0, checks_done = 0;
  cpar_regs u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .sfr_addr_i(sa), .sfr_wr_i(sw),
    .sfr_wdata_i(sd), .sfr_rdata_o(rd), .sfr_hit_o(hit), .bit_addr_i(ba), .bit_wr_i(bw),
    .bit_wdata_i(bd), .bit_rdata_o(brd), .bit_hit_o(bhit), .push_i(ps), .pop_i(pp),
    .arith_wr_i(aw), .arith_wdata_i(ad), .second_wr_i(xw), .second_wdata_i(xd),
    .ptr_word_wr_i(dw), .ptr_word_wdata_i(dd), .push_strobe_o(pstb), .push_addr_o(pa),
    .data_pointer_word_o(ptr), .primary_arith_o(arith), .second_operand_o(second),
    .stack_top_pointer_o(stk));
  always #2 mclk_i = ~mclk_i;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i) begin sa = a; sd = d; sw = 1; end
    @(negedge mclk_i) sw = 0;
  endtask : wr
  task automatic t_regs;
    logic [7:0] adr [5] = '{8'h81, 8'h82, 8'h83, 8'hE0, 8'hF0};
    for (int i = 0; i < 5; i++) begin
      wr(adr[i], 8'hA0 + 8'(i));
      `CHK("rdata", 8'hA0 + 8'(i), rd)
      `CHK("hit", 1'b1, hit)
    end
    `CHK("stack", 8'hA0, stk)
    `CHK("ptr", 16'hA2A1, ptr)
    `CHK("arith", 8'hA3, arith)
    `CHK("second", 8'hA4, second)
    wr(8'h84, 8'h5A);
    `CHK("unmapped", 9'h000, {hit, rd})
  endtask : t_regs
  task automatic t_push;
    wr(8'h81, 8'hFE);
    @(negedge mclk_i) begin ps = 1; sw = 1; sd = 8'h55; end
    @(negedge mclk_i) begin sw = 0; `CHK("push1", 17'h1FFFF, {pstb, pa, stk}) end
    @(negedge mclk_i) `CHK("push2", 17'h10000, {pstb, pa, stk})
    ps = 0;
    pp = 1;
    @(negedge mclk_i) pp = 0;
    `CHK("pop", 9'h0FF, {pstb, stk})
  endtask : t_push
  task automatic t_bits;
    @(negedge mclk_i) begin ba = 8'hE3; bd = 1; bw = 1; end
    @(negedge mclk_i) begin ba = 8'hF7; bd = 0; end
    @(negedge mclk_i) bw = 0;
    `CHK("arithbit", 8'hAB, arith)
    `CHK("secondbit", 11'h424, {bhit, brd, 1'b0, second})
  endtask : t_bits
  task automatic t_exec;
    @(negedge mclk_i) begin sa = 8'hE0; sd = 8'h11; sw = 1; aw = 1; ad = 8'hC3; end
    @(negedge mclk_i) begin sa = 8'hF0; xw = 1; xd = 8'h3C; dw = 1; dd = 16'h1234; aw = 0; end
    @(negedge mclk_i) begin sw = 0; xw = 0; dw = 0; end
    `CHK("arith", 8'hC3, arith)
    `CHK("second", 8'h3C, second)
    `CHK("ptr", 16'h1234, ptr)
  endtask : t_exec
  task automatic t_reset;
    wr(8'h81, 8'h3C);
    @(negedge mclk_i) nrst_i = 0;
    repeat (2) @(negedge mclk_i);
    nrst_i = 1;
    `CHK("midreset", 41'h00700000000, {pstb, stk, arith, second, ptr})
  endtask : t_reset
  task automatic conclude;
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(negedge mclk_i);
    nrst_i = 1;
    `CHK("rst", 24'h070000, {stk, arith, second})
    t_regs();
    t_push();
    t_bits();
    t_exec();
    t_reset();
    conclude();
  end
  initial begin
    #2000;
    miscompares++;
    conclude();
  end
endmodule : cpar_regs_tb_top
`default_nettype wire
